// ---- verilog/spm_serial_pin_mux.sv ----
// What this block does
// - eighteen serial pins, their functions picked by the interface mode and the port a and scp selects.
// - supports non-multiplexed mode plus interchip link, gci and pcm highway modes.
// - in multiplexed modes the seven-pin group feeds both serial controllers.
// - seven pins to controller one, eight to controller two or port a, three scp.
// - each shared port a pin is separately general io or dedicated function.
// - receive data pin is always an input, routed by mode.
// - transmit data optional open-drain, three-state in link and pcm, open-drain in gci.
// - receive clock pin is input in multiplexed modes, output with internal baud clock.
// - transmit clock pin is clock, pcm sync low input, or first data strobe.
// - carrier detect pin is carrier detect, line frame sync, or pcm sync high.
// - request pin is request to send, line request, gci data clock, or pcm request.
// - second data strobe leaves on port a bit seven in link and gci modes.
// - internal baud clock drives both clock pins unless clock control disables them.
// - controller two clock outputs can be disabled by port a control.
// - pcm sync pair 00 idles the line, 01/10/11 select channels one to three.
// - each pcm channel reaches the controller named in the mode register.
// - data strobes mark b1 and/or b2 slots as mode and mask registers select.
// - carrier detect event once changed level holds over more than one receive clock.
// - clear-to-send event once change holds over more than one transmit clock; optional abort.
// - request to send is active high in pcm highway mode.
// - in non-multiplexed mode request to send follows controller one having anything to send.
module spm_serial_pin_mux #(
    parameter int SLOT_BITS = spm_pkg::SLOT_BITS_DEFAULT
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // mode and clock control configuration
    input wire logic [1:0] if_mode,
    input wire logic [5:0] pcm_route,
    input wire logic strobe_mask_en,
    input wire logic [1:0] strobe1_sel,
    input wire logic [1:0] strobe2_sel,
    input wire logic ctrl1_int_clk,
    input wire logic ctrl2_int_clk,
    input wire logic clk_out_en,
    input wire logic pa_clk_out_en,
    input wire logic txd_open_drain,
    input wire logic cts_abort_en,
    input wire logic [7:0] pa_dedicated,
    input wire logic [2:0] scp_sel,
    // first controller side
    input wire logic ctrl1_txd,
    input wire logic ctrl1_tx_active,
    input wire logic ctrl1_brg_clk,
    output logic ctrl1_rxd,
    output logic ctrl1_rx_en,
    output logic ctrl1_tx_en,
    output logic ctrl1_rclk,
    output logic ctrl1_tclk,
    output logic ctrl1_cd,
    output logic ctrl1_cts,
    output logic ctrl1_cd_event,
    output logic ctrl1_cts_event,
    output logic ctrl1_tx_abort,
    // second controller side
    input wire logic ctrl2_txd,
    input wire logic ctrl2_tx_active,
    input wire logic ctrl2_brg_clk,
    output logic ctrl2_rxd,
    output logic ctrl2_rx_en,
    output logic ctrl2_tx_en,
    output logic ctrl2_rclk,
    // status/control port and general io side
    input wire logic scp_txd,
    input wire logic scp_clk,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe,
    input wire logic [2:0] scp_gpio_out,
    input wire logic [2:0] scp_gpio_oe,
    output logic [7:0] gpio_in,
    output logic [2:0] scp_in,
    output logic [1:0] pcm_channel,
    // seven-pin line group
    input wire logic receive_data_pin_in,
    input wire logic receive_clock_pin_in,
    output logic receive_clock_pin_out,
    output logic receive_clock_pin_oe,
    input wire logic transmit_clock_pin_in,
    output logic transmit_clock_pin_out,
    output logic transmit_clock_pin_oe,
    output logic transmit_data_pin_out,
    output logic transmit_data_pin_oe,
    input wire logic carrier_detect_pin_in,
    input wire logic clear_to_send_pin_in,
    output logic request_to_send_pin_out,
    // port a and scp pins
    input wire logic [7:0] port_a_pin_in,
    output logic [7:0] port_a_pin_out,
    output logic [7:0] port_a_pin_oe,
    input wire logic [2:0] scp_pin_in,
    output logic [2:0] scp_pin_out,
    output logic [2:0] scp_pin_oe
);
    localparam int CNT_W = 8;

    if (SLOT_BITS < 1 || 2 * SLOT_BITS > 255) begin : g_bad_slot
        $error("SLOT_BITS must lie in 1..127");
    end

    // true when any channel whose code matches sel routes to ctrl
    function automatic logic route_hit(input logic [1:0] sel, input logic [5:0] routes,
                                       input logic [1:0] ctrl);
        route_hit = (sel != spm_pkg::PCM_IDLE) && (routes[2*(sel-2'h1) +: 2] == ctrl);
    endfunction

    logic [1:0] mode_reg;
    logic [CNT_W-1:0] bit_cnt_reg;
    logic [CNT_W-1:0] bit_cnt_next;
    logic brg1_last_reg;
    logic [1:0] ev_filt_reg;
    logic [1:0] ev_cnt_reg [2];
    logic [1:0] ev_fire;
    logic [spm_pkg::PIN_COUNT-1:0] pin_lvl;
    logic [spm_pkg::PIN_COUNT-1:0] pin_rise;

    // every line-side pin is resynchronised before use
    spm_pin_sync #(
        .WIDTH(spm_pkg::PIN_COUNT)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .async_in({scp_pin_in, port_a_pin_in, clear_to_send_pin_in, carrier_detect_pin_in,
                   transmit_clock_pin_in, receive_clock_pin_in, receive_data_pin_in}),
        .level(pin_lvl),
        .rise(pin_rise)
    );

    // mode decode
    wire is_nmx = mode_reg == spm_pkg::MODE_NONMUX;
    wire is_idl = mode_reg == spm_pkg::MODE_IDL;
    wire is_gci = mode_reg == spm_pkg::MODE_GCI;
    wire is_pcm = mode_reg == spm_pkg::MODE_PCM;
    wire is_isdn = is_idl | is_gci;
    wire rxd_s = pin_lvl[spm_pkg::PIN_RXD];
    wire rclk_s = pin_lvl[spm_pkg::PIN_RCLK];
    wire tclk_s = pin_lvl[spm_pkg::PIN_TCLK];
    wire cd_s = pin_lvl[spm_pkg::PIN_CD];
    wire cts_s = pin_lvl[spm_pkg::PIN_CTS];
    wire [7:0] pa_s = pin_lvl[spm_pkg::PIN_PA_LSB +: spm_pkg::PA_WIDTH];
    wire [2:0] scp_s = pin_lvl[spm_pkg::PIN_SCP_LSB +: spm_pkg::SCP_WIDTH];

    // pcm channel decode from the two sync inputs
    wire [1:0] pcm_ch = {cd_s, tclk_s};
    wire c1_route = route_hit(pcm_ch, pcm_route, spm_pkg::ROUTE_CTRL_ONE);
    wire c2_route = route_hit(pcm_ch, pcm_route, spm_pkg::ROUTE_CTRL_TWO);
    wire c1_on_highway = (pcm_route[1:0] == spm_pkg::ROUTE_CTRL_ONE)
                       | (pcm_route[3:2] == spm_pkg::ROUTE_CTRL_ONE)
                       | (pcm_route[5:4] == spm_pkg::ROUTE_CTRL_ONE);

    // isdn slots counted in line clocks from the frame sync edge
    wire frame_start = is_isdn & pin_rise[spm_pkg::PIN_CD];
    wire b1_slot = bit_cnt_reg < CNT_W'(SLOT_BITS);
    wire b2_slot = !b1_slot && (bit_cnt_reg < CNT_W'(2 * SLOT_BITS));
    wire data_strobe_one = strobe_mask_en & ((strobe1_sel[spm_pkg::STROBE_B1_BIT] & b1_slot)
              | (strobe1_sel[spm_pkg::STROBE_B2_BIT] & b2_slot));
    wire data_strobe_two = strobe_mask_en & ((strobe2_sel[spm_pkg::STROBE_B1_BIT] & b1_slot)
              | (strobe2_sel[spm_pkg::STROBE_B2_BIT] & b2_slot));
    // b channels go to controller two, d channel time to controller one
    wire isdn_c2 = b1_slot | b2_slot;
    wire own_c1 = is_pcm ? c1_route : ~isdn_c2;
    wire own_c2 = is_pcm ? c2_route : isdn_c2;

    // slot counter: saturates so a lost sync cannot wrap into a slot
    always_comb begin
        bit_cnt_next = bit_cnt_reg;
        if (frame_start) begin
            bit_cnt_next = '0;
        end else if (is_isdn && pin_rise[spm_pkg::PIN_RCLK] && bit_cnt_reg != '1) begin
            bit_cnt_next = bit_cnt_reg + 1'b1;
        end
    end

    // line transmit source and activity
    wire line_txd = own_c1 ? ctrl1_txd : ctrl2_txd;
    wire line_act = (own_c1 & ctrl1_tx_active) | (own_c2 & ctrl2_tx_active);
    wire txd_out_next = is_nmx ? (~txd_open_drain & ctrl1_txd)
                      : (is_gci ? 1'b0 : line_txd);
    wire txd_oe_next = is_nmx ? (~txd_open_drain | ~ctrl1_txd)
                     : (is_gci ? (line_act & ~line_txd) : line_act);

    // clock pins: baud clock out only in non-multiplexed internal-clock mode
    wire c1_clk_drive = is_nmx & ctrl1_int_clk & clk_out_en;
    wire rclk_oe_next = c1_clk_drive;
    wire tclk_oe_next = c1_clk_drive | is_isdn;
    wire tclk_out_next = is_isdn ? data_strobe_one : ctrl1_brg_clk;
    wire c1_int = is_nmx & ctrl1_int_clk;
    wire rclk_c1 = c1_int ? ctrl1_brg_clk : rclk_s;
    wire tclk_c1 = is_nmx ? (ctrl1_int_clk ? ctrl1_brg_clk : tclk_s) : rclk_s;

    // request pin function per mode
    wire rts_next = is_nmx ? ~ctrl1_tx_active
                  : is_idl ? ctrl1_tx_active
                  : is_gci ? rclk_s
                  : (ctrl1_tx_active & c1_on_highway);

    // port a dedicated functions
    wire c2_clk_drive = pa_clk_out_en & (is_nmx ? ctrl2_int_clk : 1'b1);
    wire [7:0] pa_ded_out = {
        is_isdn ? data_strobe_two : ctrl2_brg_clk,
        1'b0,
        is_pcm ? ctrl2_tx_active : ~ctrl2_tx_active,
        1'b0,
        ctrl2_brg_clk,
        ctrl2_brg_clk,
        ctrl2_txd,
        1'b0
    };
    wire [7:0] pa_ded_oe = {1'b1, 1'b0, 1'b1, 1'b0, c2_clk_drive,
                            is_nmx & c2_clk_drive, 1'b1, 1'b0};
    wire [7:0] pa_out_next = (pa_dedicated & pa_ded_out) | (~pa_dedicated & gpio_out);
    wire [7:0] pa_oe_next = (pa_dedicated & pa_ded_oe) | (~pa_dedicated & gpio_oe);
    wire [2:0] scp_out_next = (scp_sel & {scp_clk, scp_txd, 1'b0})
                            | (~scp_sel & scp_gpio_out);
    wire [2:0] scp_oe_next = (scp_sel & 3'h6) | (~scp_sel & scp_gpio_oe);
    wire c2_ded_nmx = is_nmx & pa_dedicated[spm_pkg::PA_RXD];
    wire rclk_c2 = is_nmx ? (ctrl2_int_clk ? ctrl2_brg_clk : pa_s[spm_pkg::PA_RCLK]) : rclk_s;

    // brg edge serves as the receive/transmit clock when internal
    wire brg1_rise = ctrl1_brg_clk & ~brg1_last_reg;
    wire rx_edge = c1_int ? brg1_rise : pin_rise[spm_pkg::PIN_RCLK];
    wire tx_edge = c1_int ? brg1_rise : pin_rise[spm_pkg::PIN_TCLK];
    wire [1:0] ev_raw = {cts_s, cd_s};
    wire [1:0] ev_edge = {tx_edge, rx_edge};

    // change filters: a new level must persist beyond one line clock
    for (genvar i = 0; i < 2; i++) begin : g_event
        assign ev_fire[i] = is_nmx && ev_raw[i] != ev_filt_reg[i]
                          && ev_edge[i] && ev_cnt_reg[i] == spm_pkg::EVENT_EDGES - 2'h1;
        always_ff @(posedge ref_clk) begin
            if (srst) begin
                ev_filt_reg[i] <= 1'b1;
                ev_cnt_reg[i] <= 2'h0;
            end else if (ev_raw[i] == ev_filt_reg[i] || !is_nmx) begin
                ev_cnt_reg[i] <= 2'h0;
            end else if (ev_fire[i]) begin
                ev_filt_reg[i] <= ev_raw[i];
                ev_cnt_reg[i] <= 2'h0;
            end else if (ev_edge[i]) begin
                ev_cnt_reg[i] <= ev_cnt_reg[i] + 2'h1;
            end
        end
    end

    // state and mode capture; the mode register takes if_mode on every clock
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_reg <= spm_pkg::MODE_NONMUX;
            bit_cnt_reg <= '1;
            brg1_last_reg <= 1'b0;
        end else begin
            mode_reg <= if_mode;
            bit_cnt_reg <= bit_cnt_next;
            brg1_last_reg <= ctrl1_brg_clk;
        end
    end

    // line group and controller outputs, all registered
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            transmit_data_pin_out <= 1'b1;
            transmit_data_pin_oe <= 1'b0;
            receive_clock_pin_out <= 1'b0;
            receive_clock_pin_oe <= 1'b0;
            transmit_clock_pin_out <= 1'b0;
            transmit_clock_pin_oe <= 1'b0;
            request_to_send_pin_out <= 1'b1;
            ctrl1_rxd <= 1'b1;
            ctrl1_rx_en <= 1'b0;
            ctrl1_tx_en <= 1'b0;
            ctrl1_rclk <= 1'b0;
            ctrl1_tclk <= 1'b0;
            ctrl1_cd <= 1'b1;
            ctrl1_cts <= 1'b1;
            ctrl1_cd_event <= 1'b0;
            ctrl1_cts_event <= 1'b0;
            ctrl1_tx_abort <= 1'b0;
            pcm_channel <= spm_pkg::PCM_IDLE;
        end else begin
            transmit_data_pin_out <= txd_out_next;
            transmit_data_pin_oe <= txd_oe_next;
            receive_clock_pin_out <= ctrl1_brg_clk;
            receive_clock_pin_oe <= rclk_oe_next;
            transmit_clock_pin_out <= tclk_out_next;
            transmit_clock_pin_oe <= tclk_oe_next;
            request_to_send_pin_out <= rts_next;
            ctrl1_rxd <= rxd_s;
            ctrl1_rx_en <= is_nmx | own_c1;
            ctrl1_tx_en <= is_nmx | own_c1;
            ctrl1_rclk <= rclk_c1;
            ctrl1_tclk <= tclk_c1;
            ctrl1_cd <= ev_filt_reg[spm_pkg::EVENT_CD];
            ctrl1_cts <= ev_filt_reg[spm_pkg::EVENT_CTS];
            ctrl1_cd_event <= ev_fire[spm_pkg::EVENT_CD];
            ctrl1_cts_event <= ev_fire[spm_pkg::EVENT_CTS];
            ctrl1_tx_abort <= ev_fire[spm_pkg::EVENT_CTS] & cts_abort_en;
            pcm_channel <= is_pcm ? pcm_ch : spm_pkg::PCM_IDLE;
        end
    end

    // port a, scp and second controller outputs
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            port_a_pin_out <= 8'h00;
            port_a_pin_oe <= 8'h00;
            scp_pin_out <= 3'h0;
            scp_pin_oe <= 3'h0;
            gpio_in <= 8'h00;
            scp_in <= 3'h0;
            ctrl2_rxd <= 1'b1;
            ctrl2_rx_en <= 1'b0;
            ctrl2_tx_en <= 1'b0;
            ctrl2_rclk <= 1'b0;
        end else begin
            port_a_pin_out <= pa_out_next;
            port_a_pin_oe <= pa_oe_next;
            scp_pin_out <= scp_out_next;
            scp_pin_oe <= scp_oe_next;
            gpio_in <= pa_s;
            scp_in <= scp_s;
            ctrl2_rxd <= is_nmx ? pa_s[spm_pkg::PA_RXD] : rxd_s;
            ctrl2_rx_en <= c2_ded_nmx | (~is_nmx & own_c2);
            ctrl2_tx_en <= c2_ded_nmx | (~is_nmx & own_c2);
            ctrl2_rclk <= rclk_c2;
        end
    end

    property p_pcm_idle;
        @(posedge ref_clk) disable iff (srst)
        is_pcm && pcm_ch == spm_pkg::PCM_IDLE |=> !transmit_data_pin_oe && !ctrl1_rx_en;
    endproperty
    a_pcm_idle: assert property (p_pcm_idle) else $error("pcm idle slot not released");

    property p_rxd_path;
        @(posedge ref_clk) disable iff (srst)
        1'b1 |=> ctrl1_rxd == $past(rxd_s);
    endproperty
    a_rxd_path: assert property (p_rxd_path) else $error("receive data not forwarded");

    property p_gci_od;
        @(posedge ref_clk) disable iff (srst)
        is_gci |=> !transmit_data_pin_out;
    endproperty
    a_gci_od: assert property (p_gci_od) else $error("gci transmit drove high");

    property p_rclk_in;
        @(posedge ref_clk) disable iff (srst)
        !is_nmx ##1 !is_nmx |-> !receive_clock_pin_oe;
    endproperty
    a_rclk_in: assert property (p_rclk_in) else $error("receive clock driven in mux mode");

    property p_data_strobe_one;
        @(posedge ref_clk) disable iff (srst)
        is_isdn |=> transmit_clock_pin_oe && transmit_clock_pin_out == $past(data_strobe_one);
    endproperty
    a_data_strobe_one: assert property (p_data_strobe_one) else $error("first strobe not on clock pin");

    property p_clk_drive;
        @(posedge ref_clk) disable iff (srst)
        is_nmx && ctrl1_int_clk && clk_out_en |=> receive_clock_pin_oe && transmit_clock_pin_oe;
    endproperty
    a_clk_drive: assert property (p_clk_drive) else $error("baud clock not driven");

    property p_cd_event;
        @(posedge ref_clk) disable iff (srst)
        ctrl1_cd_event |=> ctrl1_cd != $past(ctrl1_cd) && !ctrl1_cd_event;
    endproperty
    a_cd_event: assert property (p_cd_event) else $error("cd event without level change");

    property p_rts_pcm;
        @(posedge ref_clk) disable iff (srst)
        is_pcm && ctrl1_tx_active && c1_on_highway |=> request_to_send_pin_out;
    endproperty
    a_rts_pcm: assert property (p_rts_pcm) else $error("pcm request not high");

    property p_rts_nmx;
        @(posedge ref_clk) disable iff (srst)
        is_nmx && ctrl1_tx_active |=> !request_to_send_pin_out;
    endproperty
    a_rts_nmx: assert property (p_rts_nmx) else $error("request not asserted low");

    property p_pa_clk_off;
        @(posedge ref_clk) disable iff (srst)
        !pa_clk_out_en && pa_dedicated[spm_pkg::PA_TCLK] |=> !port_a_pin_oe[spm_pkg::PA_TCLK];
    endproperty
    a_pa_clk_off: assert property (p_pa_clk_off) else $error("second clock not disabled");

    property p_strobe2;
        @(posedge ref_clk) disable iff (srst)
        is_isdn && pa_dedicated[spm_pkg::PA_STROBE]
        |=> port_a_pin_out[spm_pkg::PA_STROBE] == $past(data_strobe_two);
    endproperty
    a_strobe2: assert property (p_strobe2) else $error("second strobe missing");

    c_pcm_ch3: cover property (@(posedge ref_clk) disable iff (srst) is_pcm && pcm_ch == 2'h3);
    c_cts_abort: cover property (@(posedge ref_clk) disable iff (srst) ctrl1_tx_abort);
    c_b2_strobe: cover property (@(posedge ref_clk) disable iff (srst) is_idl && b2_slot && data_strobe_one);
endmodule // spm_serial_pin_mux

// ---- verilog/spm_pkg.sv ----
package spm_pkg;
    // interface mode codes, as held in the mode register field
    localparam logic [1:0] MODE_NONMUX = 2'h0;
    localparam logic [1:0] MODE_IDL = 2'h1;
    localparam logic [1:0] MODE_GCI = 2'h2;
    localparam logic [1:0] MODE_PCM = 2'h3;

    // pcm channel route codes, one per channel
    localparam logic [1:0] ROUTE_NONE = 2'h0;
    localparam logic [1:0] ROUTE_CTRL_ONE = 2'h1;
    localparam logic [1:0] ROUTE_CTRL_TWO = 2'h2;

    // decoded pcm sync pair {sync_high, sync_low}
    localparam logic [1:0] PCM_IDLE = 2'h0;
    localparam int PCM_CHANNELS = 3;

    // strobe select field bits
    localparam int STROBE_B1_BIT = 0;
    localparam int STROBE_B2_BIT = 1;

    // positions in the synchronised pin vector
    localparam int PIN_RXD = 0;
    localparam int PIN_RCLK = 1;
    localparam int PIN_TCLK = 2;
    localparam int PIN_CD = 3;
    localparam int PIN_CTS = 4;
    localparam int PIN_PA_LSB = 5;
    localparam int PA_WIDTH = 8;
    localparam int PIN_SCP_LSB = 13;
    localparam int SCP_WIDTH = 3;
    localparam int PIN_COUNT = 16;

    // port a bit roles when dedicated
    localparam int PA_RXD = 0;
    localparam int PA_TXD = 1;
    localparam int PA_RCLK = 2;
    localparam int PA_TCLK = 3;
    localparam int PA_RTS = 5;
    localparam int PA_STROBE = 7;

    // event filter: level must differ across this many clock edges
    localparam logic [1:0] EVENT_EDGES = 2'h2;
    localparam int EVENT_CD = 0;
    localparam int EVENT_CTS = 1;

    // default isdn b slot length in line clocks
    localparam int SLOT_BITS_DEFAULT = 8;
endpackage

// ---- verilog/spm_pin_sync.sv ----
module spm_pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // asynchronous pins
    input wire logic [WIDTH-1:0] async_in,
    // synchronised level and rising edge
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] stable_reg;
    logic [WIDTH-1:0] last_reg;

    // first stage feeds only the second; both fill during reset, which must span two edges
    always_ff @(posedge ref_clk) begin
        meta_reg <= async_in;
        stable_reg <= meta_reg;
    end

    // edge memory held high in reset so an idle-high pin gives no false edge
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            last_reg <= '1;
        end else begin
            last_reg <= stable_reg;
        end
    end

    // edges seen only on settled stages
    assign level = stable_reg;
    assign rise = stable_reg & ~last_reg;
endmodule // spm_pin_sync

// ---- dv/spm_line_model.sv ----
module spm_line_model (
    // frame control and line levels from the bench
    input wire logic run,
    input wire logic rx_bit,
    input wire logic [1:0] sync,
    // line pins
    output logic receive_clock_pin_in,
    output logic receive_data_pin_in,
    output logic carrier_detect_pin_in,
    output logic transmit_clock_pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // line clock stands low between frames so no stray edges reach the filters
    initial begin
        receive_clock_pin_in = 1'b0;
        forever begin
            #62.5;
            receive_clock_pin_in = run ? ~receive_clock_pin_in : 1'b0;
        end
    end
    // receive data and the sync pair, levels held by the far side
    assign receive_data_pin_in = rx_bit;
    assign carrier_detect_pin_in = sync[1];
    assign transmit_clock_pin_in = sync[0];
endmodule // spm_line_model

// ---- dv/tb_spm_serial_pin_mux.sv ----
module tb_spm_serial_pin_mux;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, srst, strobe_mask_en, ctrl1_int_clk, ctrl2_int_clk, clk_out_en;
    logic pa_clk_out_en, txd_open_drain, cts_abort_en, ctrl1_txd, ctrl1_tx_active;
    logic ctrl1_brg_clk, ctrl2_txd, ctrl2_tx_active, ctrl2_brg_clk, scp_txd, scp_clk;
    logic clear_to_send_pin_in, run, rx_bit;
    logic [1:0] if_mode, strobe1_sel, strobe2_sel, sync, pcm_channel;
    logic [5:0] pcm_route;
    logic [7:0] pa_dedicated, gpio_out, gpio_oe, port_a_pin_in, gpio_in;
    logic [7:0] port_a_pin_out, port_a_pin_oe;
    logic [2:0] scp_sel, scp_gpio_out, scp_gpio_oe, scp_pin_in, scp_in, scp_pin_out, scp_pin_oe;
    logic ctrl1_rxd, ctrl1_rx_en, ctrl1_tx_en, ctrl1_rclk, ctrl1_tclk, ctrl1_cd, ctrl1_cts;
    logic ctrl1_cd_event, ctrl1_cts_event, ctrl1_tx_abort, ctrl2_rxd, ctrl2_rx_en;
    logic ctrl2_tx_en, ctrl2_rclk, receive_clock_pin_out, receive_clock_pin_oe;
    logic transmit_clock_pin_out, transmit_clock_pin_oe, transmit_data_pin_out;
    logic transmit_data_pin_oe, request_to_send_pin_out;
    logic receive_clock_pin_in, receive_data_pin_in, carrier_detect_pin_in, transmit_clock_pin_in;
    int failures = 0;
    int num_checks = 0;
    // short slots keep the isdn frame walk brief
    spm_serial_pin_mux #(.SLOT_BITS(2)) u_dut (.*);
    spm_line_model u_line (.*);
    // clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // nonmux: receive data routing and low-active request
    task automatic t_nonmux();
        rx_bit = 1'b0;
        ctrl1_tx_active = 1'b1;
        step(4);
        chk("ctrl1_rxd", 1'b0, ctrl1_rxd);
        chk("rts", 1'b0, request_to_send_pin_out);
        rx_bit = 1'b1;
        ctrl1_tx_active = 1'b0;
        step(4);
        chk("ctrl1_rxd", 1'b1, ctrl1_rxd);
        chk("rts", 1'b1, request_to_send_pin_out);
        $display("t_nonmux done");
    endtask
    // port a and scp pins, each bit general io or dedicated on its own
    task automatic t_ports();
        {gpio_out, gpio_oe, pa_dedicated, port_a_pin_in} = {8'ha5, 8'hf0, 8'h02, 8'h3c};
        {ctrl2_txd, scp_sel, scp_txd, scp_pin_in} = {1'b1, 3'h2, 1'b1, 3'h5};
        step(4);
        chk("pa_out", 8'ha7, port_a_pin_out);
        chk("pa_oe", 8'hf2, port_a_pin_oe);
        chk("gpio_in", 8'h3c, gpio_in);
        chk("scp_out", 8'h02, scp_pin_out);
        chk("scp_in", 8'h05, scp_in);
        $display("t_ports done");
    endtask
    // internal baud clock on both clock pins until disabled
    task automatic t_clk();
        ctrl1_int_clk = 1'b1;
        clk_out_en = 1'b1;
        step(4);
        chk("rclk_oe", 1'b1, receive_clock_pin_oe);
        chk("tclk_oe", 1'b1, transmit_clock_pin_oe);
        ctrl1_brg_clk = 1'b1;
        step(2);
        chk("rclk_out", 1'b1, receive_clock_pin_out);
        chk("tclk_out", 1'b1, transmit_clock_pin_out);
        ctrl1_brg_clk = 1'b0;
        clk_out_en = 1'b0;
        step(4);
        chk("rclk_oe", 1'b0, receive_clock_pin_oe);
        chk("tclk_oe", 1'b0, transmit_clock_pin_oe);
        ctrl1_int_clk = 1'b0;
        $display("t_clk done");
    endtask
    // pcm highway: every sync code, channel one routed to controller one
    task automatic t_pcm();
        if_mode = spm_pkg::MODE_PCM;
        pcm_route = 6'h01;
        ctrl1_tx_active = 1'b1;
        for (int v = 0; v < 4; v++) begin
            sync = v[1:0];
            step(5);
            chk("pcm_channel0", v[0], pcm_channel[0]);
            chk("pcm_channel1", v[1], pcm_channel[1]);
            chk("ctrl1_rx_en", v == 1, ctrl1_rx_en);
            chk("txd_oe", v == 1, transmit_data_pin_oe);
            chk("rclk_oe", 1'b0, receive_clock_pin_oe);
            chk("tclk_oe", 1'b0, transmit_clock_pin_oe);
            chk("rts", 1'b1, request_to_send_pin_out);
        end
        ctrl1_tx_active = 1'b0;
        sync = 2'h3;
        $display("t_pcm done");
    endtask
    // gci: transmit data only ever pulls low
    task automatic t_gci();
        if_mode = spm_pkg::MODE_GCI;
        run = 1'b1;
        ctrl1_txd = 1'b0;
        ctrl1_tx_active = 1'b1;
        step(300);
        chk("txd_oe", 1'b1, transmit_data_pin_oe);
        chk("txd_out", 1'b0, transmit_data_pin_out);
        ctrl1_txd = 1'b1;
        step(4);
        chk("txd_oe", 1'b0, transmit_data_pin_oe);
        $display("t_gci done");
    endtask
    // link frame: strobe one in b1, strobe two in b2, b slots to controller two
    task automatic t_idl();
        logic seen;
        seen = 1'b0;
        if_mode = spm_pkg::MODE_IDL;
        {strobe_mask_en, strobe1_sel, strobe2_sel, pa_dedicated} = {1'b1, 2'h1, 2'h2, 8'h80};
        sync[1] = 1'b0;
        step(4);
        sync[1] = 1'b1;
        step(6);
        chk("tclk_out", 1'b1, transmit_clock_pin_out);
        chk("ctrl2_rx_en", 1'b1, ctrl2_rx_en);
        chk("ctrl1_rx_en", 1'b0, ctrl1_rx_en);
        for (int i = 0; i < 150; i++) begin
            step(1);
            seen |= port_a_pin_out[spm_pkg::PA_STROBE] === 1'b1;
        end
        chk("data_strobe_two_seen", 1'b1, seen);
        chk("tclk_out", 1'b0, transmit_clock_pin_out);
        chk("ctrl2_rx_en", 1'b0, ctrl2_rx_en);
        $display("t_idl done");
    endtask
    // cd and cts held low across two baud clock edges raise events
    task automatic t_event();
        logic [2:0] seen;
        seen = 3'h0;
        if_mode = spm_pkg::MODE_NONMUX;
        step(4);
        {ctrl1_int_clk, cts_abort_en, clear_to_send_pin_in, sync[1]} = 4'hc;
        for (int i = 0; i < 40; i++) begin
            ctrl1_brg_clk = ~ctrl1_brg_clk;
            step(1);
            seen |= {ctrl1_cd_event, ctrl1_cts_event, ctrl1_tx_abort};
        end
        chk("cd_event", 1'b1, seen[2]);
        chk("cts_event", 1'b1, seen[1]);
        chk("tx_abort", 1'b1, seen[0]);
        chk("ctrl1_cd", 1'b0, ctrl1_cd);
        chk("ctrl1_cts", 1'b0, ctrl1_cts);
        ctrl1_int_clk = 1'b0;
        $display("t_event done");
    endtask
    // watchdog
    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        {strobe_mask_en, ctrl1_int_clk, ctrl2_int_clk, clk_out_en, pa_clk_out_en} = '0;
        {txd_open_drain, cts_abort_en, ctrl1_txd, ctrl1_tx_active, ctrl1_brg_clk} = '0;
        {ctrl2_txd, ctrl2_tx_active, ctrl2_brg_clk, scp_txd, scp_clk, run} = '0;
        {if_mode, strobe1_sel, strobe2_sel, pcm_route, pa_dedicated} = '0;
        {gpio_out, gpio_oe, port_a_pin_in, scp_sel, scp_gpio_out, scp_gpio_oe, scp_pin_in} = '0;
        clear_to_send_pin_in = 1'b1;
        rx_bit = 1'b1;
        sync = 2'h3;
        srst = 1'b1;
        step(3);
        chk("txd_oe", 1'b0, transmit_data_pin_oe);
        chk("txd_out", 1'b1, transmit_data_pin_out);
        chk("rts", 1'b1, request_to_send_pin_out);
        chk("ctrl1_cd", 1'b1, ctrl1_cd);
        srst = 1'b0;
        t_nonmux();
        t_ports();
        t_clk();
        t_pcm();
        t_gci();
        t_idl();
        t_event();
        tally_and_finish();
    end
endmodule // tb_spm_serial_pin_mux
